// [logic/i2c_watchdog.sv]
/*
  Watchdog on the synchronised serial data input: a low level held for the
  selected period raises a one-cycle expiry pulse.
  Assumes its data input already passed a two-stage synchroniser.
*/
`timescale 1ns/10ps
`default_nettype none

module i2c_watchdog #(
  parameter int SHORT_CYC = offset_cfg_pkg::WDT_SHORT_CYC,
  parameter int LONG_CYC  = offset_cfg_pkg::WDT_LONG_CYC
) (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic run,
  input  wire logic long_sel,
  input  wire logic data_level,
  output logic      expired
);

  localparam int CW = offset_cfg_pkg::WDT_CNT_W;

  logic [CW-1:0] low_cnt_r;
  logic [CW-1:0] limit;

  // The pulse is launched as the count reaches the limit, so it follows
  // exactly the selected number of low cycles.
  assign limit = long_sel ? CW'(LONG_CYC) : CW'(SHORT_CYC);

  // The count stops at its limit so one stuck-low episode fires only once.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      low_cnt_r <= '0;
    end else if (!run || data_level) begin
      low_cnt_r <= '0;
    end else if (low_cnt_r != limit) begin
      low_cnt_r <= low_cnt_r + CW'(1);
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      expired <= 1'b0;
    end else begin
      expired <= run && !data_level && (low_cnt_r == limit - CW'(1));
    end
  end

  chk_wdt_idle: assert property (@(posedge ref_clk) disable iff (rst)
    !run |=> !expired)
    else $error("watchdog fired while not running");

  chk_wdt_period: assert property (@(posedge ref_clk) disable iff (rst)
    expired |-> $past(low_cnt_r) == $past(limit) - CW'(1))
    else $error("watchdog fired at the wrong count");

endmodule // i2c_watchdog

`default_nettype wire

// [logic/offset_adder.sv]
/*
  One axis sample with an optional signed 8-bit offset added, saturated to
  the sample width and registered.
  Assumes signed two's complement samples on the system clock.
*/
`timescale 1ns/10ps
`default_nettype none

module offset_adder #(
  parameter int DW = 16,
  parameter int OW = 8
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          add_en,
  input  wire logic [DW-1:0] sample_in,
  input  wire logic [OW-1:0] offset,
  output logic      [DW-1:0] sample_out
);

  logic signed [DW:0] sum;
  logic signed [DW:0] off_ext;
  logic [DW-1:0]      sat;

  // The sum is one bit wider so that an overflow clamps instead of wrapping.
  always_comb begin
    off_ext = add_en ? $signed({{(DW+1-OW){offset[OW-1]}}, offset}) : '0;
    sum     = $signed({sample_in[DW-1], sample_in}) + off_ext;
    if (sum[DW] != sum[DW-1]) begin
      sat = sum[DW] ? {1'b1, {(DW-1){1'b0}}} : {1'b0, {(DW-1){1'b1}}};
    end else begin
      sat = sum[DW-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sample_out <= '0;
    end else begin
      sample_out <= sat;
    end
  end

  chk_offset_bypass: assert property (@(posedge ref_clk) disable iff (rst)
    !add_en |=> sample_out == $past(sample_in))
    else $error("offset applied while disabled");

endmodule // offset_adder

`default_nettype wire

// [logic/offset_adder_fix_note.sv]
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// [logic/offset_cfg_pkg.sv]
/*
  Package for the sensor interface and offset configuration register bank:
  register offsets, field positions, write masks, reset values, command codes,
  watchdog times and the packed carriers shared by the design files.
  Assumes a single 25 MHz system clock and an 8-bit register space.
*/
// Summary of operation
// - Bit 1 of the non-volatile mode register keeps the non-volatile controller read-only at 0 and permits program and erase at 1.
// - Bit 0 of the serial interface configuration register selects four-wire SPI at 0 and three-wire SPI with a shared data line at 1.
// - The serial interface configuration register resets to zero (four-wire, auxiliary off) and an auxiliary mode of 1 selects a magnetometer.
// - Bit 0 of the self-test register enables the accelerometer self-test excitation at 1, disables it at 0, and the register resets to zero.
// - Bit 2 of the self-test register selects negative deflection at 0 and positive deflection at 1.
// - Bit 3 of the self-test register selects low excitation amplitude at 0 and high amplitude at 1.
// - In automatic configuration mode the interface-select bit at 1 disables I2C and enables SPI, and at 0 keeps I2C enabled.
// - The watchdog period select bit gives a 1.25 ms timeout at 0 and a 40 ms timeout at 1.
// - With its enable bit at 1 and the primary interface in I2C mode a watchdog runs on the serial data input pin, and at 0 it is off.
// - With the offset-enable bit at 1 each axis offset is added to both filtered and unfiltered data, and at 0 none is applied.
// - Three 8-bit read-write offset registers for X, Y and Z sit at consecutive addresses and reset to zero.
// - The persistent configuration bits and the three axis offsets are non-volatile backed and reset to zero.
// - Writing command 0xA0 to the command register copies all non-volatile backed contents into non-volatile memory.

`default_nettype none

package offset_cfg_pkg;

  // ------------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] NVM_MODE_OFFSET   = 8'h6A;
  localparam logic [7:0] SERIAL_IF_OFFSET  = 8'h6B;
  localparam logic [7:0] SELFTEST_OFFSET   = 8'h6D;
  localparam logic [7:0] PERSIST_OFFSET    = 8'h70;
  localparam logic [7:0] X_OFFSET_OFFSET   = 8'h71;
  localparam logic [7:0] Y_OFFSET_OFFSET   = 8'h72;
  localparam logic [7:0] Z_OFFSET_OFFSET   = 8'h73;
  localparam logic [7:0] COMMAND_OFFSET    = 8'h7E;

  // ------------------------------------------------------------------
  // Field positions and writable masks
  // ------------------------------------------------------------------
  localparam int PROG_EN_BIT       = 1;
  localparam int THREE_WIRE_BIT    = 0;
  localparam int AUX_MODE_BIT      = 4;
  localparam int ST_EN_BIT         = 0;
  localparam int ST_SIGN_BIT       = 2;
  localparam int ST_AMP_BIT        = 3;
  localparam int SPI_EN_BIT        = 0;
  localparam int WDT_SEL_BIT       = 1;
  localparam int WDT_EN_BIT        = 2;
  localparam int OFF_EN_BIT        = 3;

  localparam logic [7:0] NVM_MODE_MASK  = 8'h02;
  localparam logic [7:0] SERIAL_IF_MASK = 8'h11;
  localparam logic [7:0] SELFTEST_MASK  = 8'h0D;
  localparam logic [7:0] PERSIST_MASK   = 8'h0F;
  localparam logic [7:0] REG_RESET      = 8'h00;

  // ------------------------------------------------------------------
  // Commands and times
  // ------------------------------------------------------------------
  localparam logic [7:0] NVM_PROG_CMD  = 8'hA0;
  localparam int CLK_PERIOD_NS        = 40;
  localparam int WDT_SHORT_NS         = 1250000;
  localparam int WDT_LONG_NS          = 40000000;
  localparam int WDT_SHORT_CYC        = WDT_SHORT_NS / CLK_PERIOD_NS;
  localparam int WDT_LONG_CYC         = WDT_LONG_NS / CLK_PERIOD_NS;
  localparam int WDT_CNT_W            = 20;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic [7:0] conf;
    logic [7:0] off_x;
    logic [7:0] off_y;
    logic [7:0] off_z;
  } nv_image_t;

  typedef logic [2:0][15:0] axes_t;

endpackage

`default_nettype wire

// [logic/sensor_interface_offset_config.sv]
/*
  Interface and offset configuration register bank of the acceleration
  sensor, written and read by the primary serial interface logic through a
  simple register port, with the I2C watchdog, the offset path for filtered
  and unfiltered data, and the store request to the non-volatile engine.
  Assumes the serial interface logic runs on ref_clk and that the
  non-volatile programming engine accepts a one-cycle store pulse.
*/
`timescale 1ns/10ps
`default_nettype none

module sensor_interface_offset_config #(
  parameter int WDT_SHORT_CYC = offset_cfg_pkg::WDT_SHORT_CYC,
  parameter int WDT_LONG_CYC  = offset_cfg_pkg::WDT_LONG_CYC,
  parameter int DATA_W        = 16
) (
  input  wire logic                      ref_clk,
  input  wire logic                      rst,
  input  wire offset_cfg_pkg::reg_req_t  reg_req,
  output logic [7:0]                     reg_rdata,
  output logic                           reg_rvalid,
  input  wire logic                      serial_data_in_pin,
  input  wire logic                      auto_config_mode,
  input  wire offset_cfg_pkg::axes_t     accel_raw,
  input  wire offset_cfg_pkg::axes_t     accel_filt,
  output offset_cfg_pkg::axes_t          accel_raw_out,
  output offset_cfg_pkg::axes_t          accel_filt_out,
  output logic                           nvm_prog_enable,
  output logic                           three_wire_select,
  output logic                           aux_mag_select,
  output logic                           selftest_enable,
  output logic                           selftest_positive,
  output logic                           selftest_high_amp,
  output logic                           i2c_disable,
  output logic                           i2c_wdt_expired,
  output logic                           nvm_store_req,
  output offset_cfg_pkg::nv_image_t      nvm_image
);

  // ------------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------------
  logic [7:0] nvm_mode_r;
  logic [7:0] serial_if_r;
  logic [7:0] selftest_r;
  logic [7:0] persist_r;
  logic [7:0] axis_off_r [3];
  logic [7:0] rdata_nxt;
  logic       store_nxt;
  logic       sda_meta_r;
  logic       sda_sync_r;
  logic       wdt_run;

  function automatic logic wr_at(input offset_cfg_pkg::reg_req_t req, input logic [7:0] a);
    return req.wr && (req.addr == a);
  endfunction

  // ------------------------------------------------------------------
  // Writes: reserved bits are masked so they always hold zero
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nvm_mode_r <= offset_cfg_pkg::REG_RESET;
    end else if (wr_at(reg_req, offset_cfg_pkg::NVM_MODE_OFFSET)) begin
      nvm_mode_r <= reg_req.wdata & offset_cfg_pkg::NVM_MODE_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      serial_if_r <= offset_cfg_pkg::REG_RESET;
    end else if (wr_at(reg_req, offset_cfg_pkg::SERIAL_IF_OFFSET)) begin
      serial_if_r <= reg_req.wdata & offset_cfg_pkg::SERIAL_IF_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      selftest_r <= offset_cfg_pkg::REG_RESET;
    end else if (wr_at(reg_req, offset_cfg_pkg::SELFTEST_OFFSET)) begin
      selftest_r <= reg_req.wdata & offset_cfg_pkg::SELFTEST_MASK;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      persist_r <= offset_cfg_pkg::REG_RESET;
    end else if (wr_at(reg_req, offset_cfg_pkg::PERSIST_OFFSET)) begin
      persist_r <= reg_req.wdata & offset_cfg_pkg::PERSIST_MASK;
    end
  end

  // ------------------------------------------------------------------
  // Axis offsets at consecutive addresses
  // ------------------------------------------------------------------
  generate
    for (genvar i = 0; i < 3; i++) begin : g_off
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          axis_off_r[i] <= offset_cfg_pkg::REG_RESET;
        end else if (wr_at(reg_req, offset_cfg_pkg::X_OFFSET_OFFSET + 8'(i))) begin
          axis_off_r[i] <= reg_req.wdata;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  // The command register and every unmapped address read as zero.
  always_comb begin
    unique case (reg_req.addr)
      offset_cfg_pkg::NVM_MODE_OFFSET:  rdata_nxt = nvm_mode_r;
      offset_cfg_pkg::SERIAL_IF_OFFSET: rdata_nxt = serial_if_r;
      offset_cfg_pkg::SELFTEST_OFFSET:  rdata_nxt = selftest_r;
      offset_cfg_pkg::PERSIST_OFFSET:   rdata_nxt = persist_r;
      offset_cfg_pkg::X_OFFSET_OFFSET:  rdata_nxt = axis_off_r[0];
      offset_cfg_pkg::Y_OFFSET_OFFSET:  rdata_nxt = axis_off_r[1];
      offset_cfg_pkg::Z_OFFSET_OFFSET:  rdata_nxt = axis_off_r[2];
      default:                          rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata <= rdata_nxt;
      end
    end
  end

  // ------------------------------------------------------------------
  // Control outputs
  // ------------------------------------------------------------------
  assign nvm_prog_enable   = nvm_mode_r[offset_cfg_pkg::PROG_EN_BIT];
  assign three_wire_select = serial_if_r[offset_cfg_pkg::THREE_WIRE_BIT];
  assign aux_mag_select    = serial_if_r[offset_cfg_pkg::AUX_MODE_BIT];
  assign selftest_enable   = selftest_r[offset_cfg_pkg::ST_EN_BIT];
  assign selftest_positive = selftest_r[offset_cfg_pkg::ST_SIGN_BIT];
  assign selftest_high_amp = selftest_r[offset_cfg_pkg::ST_AMP_BIT];
  // Outside automatic configuration the interface keeps its own choice.
  assign i2c_disable = auto_config_mode && persist_r[offset_cfg_pkg::SPI_EN_BIT];

  // ------------------------------------------------------------------
  // I2C watchdog on the data pin
  // ------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
    end else begin
      sda_meta_r <= serial_data_in_pin;
      sda_sync_r <= sda_meta_r;
    end
  end

  assign wdt_run = persist_r[offset_cfg_pkg::WDT_EN_BIT] && !i2c_disable;

  i2c_watchdog #(
    .SHORT_CYC (WDT_SHORT_CYC),
    .LONG_CYC  (WDT_LONG_CYC)
  ) u_wdt (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .run        (wdt_run),
    .long_sel   (persist_r[offset_cfg_pkg::WDT_SEL_BIT]),
    .data_level (sda_sync_r),
    .expired    (i2c_wdt_expired)
  );

  // ------------------------------------------------------------------
  // Offset path for unfiltered and filtered data
  // ------------------------------------------------------------------
  generate
    for (genvar a = 0; a < 3; a++) begin : g_axis
      offset_adder #(.DW(DATA_W), .OW(8)) u_raw (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .add_en     (persist_r[offset_cfg_pkg::OFF_EN_BIT]),
        .sample_in  (accel_raw[a]),
        .offset     (axis_off_r[a]),
        .sample_out (accel_raw_out[a])
      );
      offset_adder #(.DW(DATA_W), .OW(8)) u_filt (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .add_en     (persist_r[offset_cfg_pkg::OFF_EN_BIT]),
        .sample_in  (accel_filt[a]),
        .offset     (axis_off_r[a]),
        .sample_out (accel_filt_out[a])
      );
    end
  endgenerate

  // ------------------------------------------------------------------
  // Store to non-volatile memory
  // ------------------------------------------------------------------
  // Without the programming enable the controller stays read-only, so the
  // command is dropped rather than queued.
  assign store_nxt = wr_at(reg_req, offset_cfg_pkg::COMMAND_OFFSET)
                     && (reg_req.wdata == offset_cfg_pkg::NVM_PROG_CMD)
                     && nvm_prog_enable;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nvm_store_req <= 1'b0;
    end else begin
      nvm_store_req <= store_nxt;
    end
  end

  // The image is frozen at the command so later writes cannot tear it.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nvm_image <= '0;
    end else if (store_nxt) begin
      nvm_image <= '{conf: persist_r, off_x: axis_off_r[0],
                     off_y: axis_off_r[1], off_z: axis_off_r[2]};
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_prog_cmd;
    reg_req.wr && reg_req.addr == offset_cfg_pkg::COMMAND_OFFSET
      && reg_req.wdata == offset_cfg_pkg::NVM_PROG_CMD;
  endsequence

  chk_store_gated: assert property (@(posedge ref_clk) disable iff (rst)
    s_prog_cmd ##0 !nvm_prog_enable |=> !nvm_store_req)
    else $error("store issued while read-only");

  chk_store_issued: assert property (@(posedge ref_clk) disable iff (rst)
    s_prog_cmd ##0 nvm_prog_enable |=> nvm_store_req
      && nvm_image.conf == $past(persist_r))
    else $error("store command not followed by store pulse");

  chk_wire_mode: assert property (@(posedge ref_clk) disable iff (rst)
    reg_req.wr && reg_req.addr == offset_cfg_pkg::SERIAL_IF_OFFSET
      |=> three_wire_select == $past(reg_req.wdata[0])
      && aux_mag_select == $past(reg_req.wdata[4]))
    else $error("interface mode not taken from write");

  chk_if_reset: assert property (@(posedge ref_clk)
    $fell(rst) |-> !three_wire_select && !aux_mag_select && !selftest_enable)
    else $error("configuration not zero after reset");

  chk_selftest_bits: assert property (@(posedge ref_clk) disable iff (rst)
    reg_req.wr && reg_req.addr == offset_cfg_pkg::SELFTEST_OFFSET
      |=> {selftest_high_amp, selftest_positive, selftest_enable}
        == {$past(reg_req.wdata[3]), $past(reg_req.wdata[2]), $past(reg_req.wdata[0])})
    else $error("self-test fields not taken from write");

  chk_i2c_select: assert property (@(posedge ref_clk) disable iff (rst)
    i2c_disable |-> auto_config_mode && persist_r[0])
    else $error("I2C disabled without request");

  chk_offset_read: assert property (@(posedge ref_clk) disable iff (rst)
    reg_req.wr && reg_req.addr == offset_cfg_pkg::Y_OFFSET_OFFSET ##1
      reg_req.rd && reg_req.addr == offset_cfg_pkg::Y_OFFSET_OFFSET && !reg_req.wr
      |=> reg_rvalid && reg_rdata == $past(reg_req.wdata, 2))
    else $error("offset read-back mismatch");

  chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst)
    reg_rvalid |-> !(($past(reg_req.addr) == offset_cfg_pkg::SELFTEST_OFFSET) && reg_rdata[1])
      && !(($past(reg_req.addr) == offset_cfg_pkg::COMMAND_OFFSET) && |reg_rdata))
    else $error("reserved or command bits read non-zero");

  sequence s_persist_write;
    reg_req.wr && reg_req.addr == offset_cfg_pkg::PERSIST_OFFSET;
  endsequence

  sequence s_read_only_req;
    reg_req.rd && !reg_req.wr;
  endsequence

  chk_prog_write: assert property (@(posedge ref_clk) disable iff (rst)
    reg_req.wr && reg_req.addr == offset_cfg_pkg::NVM_MODE_OFFSET
      |=> nvm_prog_enable == $past(reg_req.wdata[1]))
    else $error("programming enable not taken from write");

  chk_persist_mask: assert property (@(posedge ref_clk) disable iff (rst)
    s_persist_write |=> persist_r == ($past(reg_req.wdata) & offset_cfg_pkg::PERSIST_MASK))
    else $error("persistent configuration not masked on write");

  chk_spi_request: assert property (@(posedge ref_clk) disable iff (rst)
    s_persist_write ##1 auto_config_mode |-> i2c_disable == $past(reg_req.wdata[0]))
    else $error("interface select not taken from write");

  chk_wdt_gate: assert property (@(posedge ref_clk) disable iff (rst)
    !persist_r[offset_cfg_pkg::WDT_EN_BIT] |=> !i2c_wdt_expired)
    else $error("watchdog fired while disabled");

  chk_read_answer: assert property (@(posedge ref_clk) disable iff (rst)
    s_read_only_req |=> reg_rvalid)
    else $error("read not answered on the next cycle");

  chk_image_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !nvm_store_req |-> $stable(nvm_image))
    else $error("stored image changed without a store");

endmodule // sensor_interface_offset_config

`default_nettype wire

// [verif/host_model.sv]
/*
  Host side of the register port: drives write and read requests.
  Assumes requests are driven at the falling edge of ref_clk.
*/
`timescale 1ns/10ps
`default_nettype none

module host_model (
  input  wire logic                    ref_clk,
  output offset_cfg_pkg::reg_req_t     reg_req,
  input  wire logic [7:0]              reg_rdata,
  input  wire logic                    reg_rvalid
);
  initial reg_req = '0;

  // Released address and data lines show the inverse of the last value.
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge ref_clk);
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  // Waits a bounded time for the answer to a read that was just released.
  task automatic collect(output logic [7:0] d, output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 3 && !ok; i++) begin
      if (reg_rvalid === 1'b1) begin
        ok = 1'b1;
        d = reg_rdata;
      end else begin
        @(negedge ref_clk);
      end
    end
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(negedge ref_clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5A};
    @(negedge ref_clk);
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
    collect(d, ok);
  endtask

  // Write, then read the same register on the very next edge.
  task automatic write_read(input logic [7:0] a, input logic [7:0] wd,
                            output logic [7:0] d, output logic ok);
    @(negedge ref_clk);
    reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: wd};
    @(negedge ref_clk);
    reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~wd};
    @(negedge ref_clk);
    reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
    collect(d, ok);
  endtask

  task automatic store_cmd(input logic [7:0] code);
    write_reg(offset_cfg_pkg::COMMAND_OFFSET, code);
  endtask
endmodule // host_model

`default_nettype wire

// [verif/testbench.sv]
/*
  Self-checking bench of the configuration register bank.
  Assumes short watchdog counts of 8 and 20 cycles.
*/
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_mismatch++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (a), (b)); end end

module testbench;
  logic                      ref_clk = 1'b0;
  logic                      rst = 1'b1;
  offset_cfg_pkg::reg_req_t  reg_req;
  logic [7:0]                reg_rdata;
  logic                      reg_rvalid;
  logic                      pin = 1'b1;
  logic                      auto_cfg = 1'b0;
  offset_cfg_pkg::axes_t     raw = '0;
  offset_cfg_pkg::axes_t     filt = '0;
  offset_cfg_pkg::axes_t     raw_out;
  offset_cfg_pkg::axes_t     filt_out;
  logic [5:0]                cfg_out;
  logic                      i2c_dis;
  logic                      expired;
  logic                      store;
  offset_cfg_pkg::nv_image_t image;
  int                        n_mismatch = 0;
  int                        check_count = 0;

  always #20 ref_clk = ~ref_clk;

  host_model host_model_i (.ref_clk(ref_clk), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid));

  sensor_interface_offset_config #(.WDT_SHORT_CYC(8), .WDT_LONG_CYC(20))
    sensor_interface_offset_config_i (.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .serial_data_in_pin(pin),
    .auto_config_mode(auto_cfg), .accel_raw(raw), .accel_filt(filt),
    .accel_raw_out(raw_out), .accel_filt_out(filt_out), .nvm_prog_enable(cfg_out[0]),
    .three_wire_select(cfg_out[1]), .aux_mag_select(cfg_out[2]),
    .selftest_enable(cfg_out[3]), .selftest_positive(cfg_out[4]),
    .selftest_high_amp(cfg_out[5]), .i2c_disable(i2c_dis), .i2c_wdt_expired(expired),
    .nvm_store_req(store), .nvm_image(image));

  logic [7:0] offs [8] = '{8'h6A, 8'h6B, 8'h6D, 8'h70, 8'h71, 8'h72, 8'h73, 8'h6C};
  logic [7:0] msks [8] = '{8'h02, 8'h11, 8'h0D, 8'h0F, 8'hFF, 8'hFF, 8'hFF, 8'h00};

  task automatic tally_and_finish();
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    logic       ok;
    host_model_i.read_reg(a, d, ok);
    if (!ok) begin
      n_mismatch++;
      tally_and_finish();
    end
    `CHK(d, e)
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    for (int i = 0; i < 8; i++) rd_chk(offs[i], 8'h00);
    `CHK(cfg_out, 6'h00)
  endtask

  task automatic t_masks();
    for (int i = 0; i < 8; i++) begin
      host_model_i.write_reg(offs[i], 8'hFF);
      rd_chk(offs[i], msks[i]);
    end
    rd_chk(8'h7E, 8'h00);
    `CHK(cfg_out, 6'h3F)
    for (int i = 0; i < 4; i++) host_model_i.write_reg(offs[i], 8'h00);
    `CHK(cfg_out, 6'h00)
  endtask

  task automatic t_spi_sel();
    host_model_i.write_reg(8'h70, 8'h01);
    `CHK(i2c_dis, 1'b0)
    auto_cfg = 1'b1;
    #1 `CHK(i2c_dis, 1'b1)
    host_model_i.write_reg(8'h70, 8'h00);
    `CHK(i2c_dis, 1'b0)
    auto_cfg = 1'b0;
  endtask

  task automatic t_offset();
    logic [7:0] d;
    logic       ok;
    host_model_i.write_reg(8'h71, 8'h05);
    host_model_i.write_read(8'h72, 8'hFD, d, ok);
    if (!ok) begin
      n_mismatch++;
      tally_and_finish();
    end
    `CHK(d, 8'hFD)
    host_model_i.write_reg(8'h73, 8'h80);
    host_model_i.write_reg(8'h70, 8'h08);
    raw = '{16'h0000, 16'h0010, 16'h7FFF};
    filt = '{16'h0100, 16'h8000, 16'h0001};
    @(negedge ref_clk);
    `CHK(raw_out, {16'hFF80, 16'h000D, 16'h7FFF})
    `CHK(filt_out, {16'h0080, 16'h8000, 16'h0006})
    host_model_i.write_reg(8'h70, 8'h00);
    @(negedge ref_clk);
    `CHK(raw_out, raw)
    `CHK(filt_out, filt)
  endtask

  task automatic t_store();
    host_model_i.write_reg(8'h70, 8'h08);
    host_model_i.store_cmd(8'hA0);
    `CHK(store, 1'b0)
    host_model_i.write_reg(8'h6A, 8'h02);
    host_model_i.store_cmd(8'hB0);
    `CHK(store, 1'b0)
    host_model_i.store_cmd(8'hA0);
    `CHK(store, 1'b1)
    `CHK(image, 32'h0805FD80)
    @(negedge ref_clk);
    `CHK(store, 1'b0)
  endtask

  task automatic wdt_run(input logic [7:0] conf, input int lo, input int hi);
    int n;
    host_model_i.write_reg(8'h70, conf);
    pin = 1'b0;
    n = 0;
    while (expired !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    pin = 1'b1;
    repeat (4) @(negedge ref_clk);
    if (n == 40 && hi < 40) begin
      n_mismatch++;
      tally_and_finish();
    end
    `CHK(n >= lo && n <= hi, 1'b1)
  endtask

  task automatic t_wdt();
    wdt_run(8'h04, 8, 11);
    wdt_run(8'h06, 20, 23);
    wdt_run(8'h00, 40, 40);
    auto_cfg = 1'b1;
    wdt_run(8'h05, 40, 40);
    auto_cfg = 1'b0;
  endtask

  initial begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    t_reset();
    t_masks();
    t_spi_sel();
    t_offset();
    t_store();
    t_wdt();
    tally_and_finish();
  end
endmodule // testbench

`default_nettype wire
